/* File: pkg/mci_regs.svh */
`ifndef MCI_REGS_SVH
`define MCI_REGS_SVH
// Functional notes
// - Fired, enabled source with defined vector suspends program and calls handler.
// - Accumulator, X register and flags are saved before handler entry.
// - No nesting; other interrupts blocked while a handler runs.
// - Return-from-interrupt restores context and resumes at the saved address.
// - Extended opcodes accepted only from firmware revision 1.46 on.
// - Opcodes 40 to 45 are variable arithmetic operations.
// - 46 moves to accumulator position, 50 spins negative, 51 spins positive.
// - 48 restarts program, 49 decrements and branches, 80 calls conditionally.
// - 55 writes, 56 reads, 57 copies accumulator to indexed variable.
// - Spin positive runs motor so the position counter increments.
// - Spin negative runs motor so the position counter decrements.
// - Spin commands select velocity mode and load target velocity parameter 2 in the same cycle.
// - Soft halt selects velocity mode and clears target velocity to zero.
// - Each source has its own vector by number; 255 is the global enable.
// - Host value reads leave the accumulator untouched.

// Opcodes
`define MCI_OP_SPIN_POS       8'h01
`define MCI_OP_SPIN_NEG       8'h02
`define MCI_OP_SOFT_HALT      8'h03
`define MCI_OP_GOTO_POS       8'h04
`define MCI_OP_SET_AXIS       8'h05
`define MCI_OP_GET_AXIS       8'h06
`define MCI_OP_SET_GLOBAL     8'h09
`define MCI_OP_GET_GLOBAL     8'h0a
`define MCI_OP_CALC           8'h13
`define MCI_OP_COMPARE        8'h14
`define MCI_OP_JUMP_COND      8'h15
`define MCI_OP_JUMP           8'h16
`define MCI_OP_CALL_SUB       8'h17
`define MCI_OP_RET_SUB        8'h18
`define MCI_OP_IRQ_ENABLE     8'h19
`define MCI_OP_IRQ_DISABLE    8'h1a
`define MCI_OP_PROG_STOP      8'h1c
`define MCI_OP_CALCX          8'h21
`define MCI_OP_ACC_TO_AXIS    8'h22
`define MCI_OP_SET_VECTOR     8'h25
`define MCI_OP_RET_IRQ        8'h26
`define MCI_OP_ARITH_FIRST    8'h28
`define MCI_OP_ARITH_LAST     8'h2d
`define MCI_OP_GOTO_POS_ACC   8'h2e
`define MCI_OP_RESTART        8'h30
`define MCI_OP_DEC_BRANCH     8'h31
`define MCI_OP_SPIN_NEG_ACC   8'h32
`define MCI_OP_SPIN_POS_ACC   8'h33
`define MCI_OP_WRITE_IDX      8'h37
`define MCI_OP_READ_IDX       8'h38
`define MCI_OP_ACC_TO_IDX     8'h39
`define MCI_OP_COND_CALL      8'h50

// Axis parameters and interrupt numbers
`define MCI_AP_TARGET_POS     8'h00
`define MCI_AP_TARGET_VEL     8'h02
`define MCI_GP_IRQ_BANK       8'h03
`define MCI_IRQ_GLOBAL        8'hff
`define MCI_IRQ_SOURCES       3
`define MCI_EXT_MIN_REV       16'h012e
`define MCI_PC_RESET          10'h000
`define MCI_CALCX_LOAD_X      8'h00   // Calculation type that copies acc into X
`endif

/* File: pkg/mci_pkg.sv */
package mci_pkg;
  typedef enum logic [3:0] {
    MCI_RUN    = 4'b0001,
    MCI_SAVE   = 4'b0010,
    MCI_HANDLE = 4'b0100,
    MCI_REST   = 4'b1000
  } mci_state_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [3:0]  flags;
    logic [9:0]  pc;
  } mci_ctx_t;

  typedef enum logic [1:0] {
    MCI_MODE_POS = 2'h0,
    MCI_MODE_VEL = 2'h1
  } mci_mode_t;
endpackage

/* File: pkg/mci_ctx_if.sv */
interface mci_ctx_if;
  import mci_pkg::*;
  logic     save;
  logic     restore;
  mci_ctx_t wdata;
  mci_ctx_t rdata;
  modport core (output save, output restore, output wdata, input rdata);
  modport store (input save, input restore, input wdata, output rdata);
endinterface

/* File: hdl/mci_ctx_store.sv */
// Holds the suspended program context while a handler runs
module mci_ctx_store
  import mci_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  mci_ctx_if.store  ctx
);
  mci_ctx_t saved_q;

  // Capture on save, present registered copy
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      saved_q <= '0;
    end else if (ctx.save) begin
      saved_q <= ctx.wdata;
    end
  end

  assign ctx.rdata = saved_q;
endmodule

/* File: hdl/mci_engine.sv */
`include "mci_regs.svh"
// Interrupt dispatch and motion command execution
module mci_engine
  import mci_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_fw_rev,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_direct,
  input  wire logic [7:0]  i_cmd_op,
  input  wire logic [7:0]  i_cmd_type,
  input  wire logic [7:0]  i_cmd_motor,
  input  wire logic [31:0] i_cmd_value,
  input  wire logic [31:0] i_read_value,
  input  wire logic [3:0]  i_flags_new,
  input  wire logic        i_flags_we,
  input  wire logic [2:0]  i_irq_src,
  output logic             o_cmd_ready,
  output logic             o_cmd_known,
  output logic [9:0]       o_pc,
  output logic             o_in_handler,
  output logic [31:0]      o_acc,
  output logic [31:0]      o_xreg,
  output logic [3:0]       o_flags,
  output logic             o_axis_we,
  output logic [7:0]       o_axis_param,
  output logic [7:0]       o_axis_motor,
  output logic [31:0]      o_axis_value,
  output logic [1:0]       o_axis_mode,
  output logic             o_dir_positive,
  output logic             o_restart
);
  localparam int NSRC = `MCI_IRQ_SOURCES;

  // True when the opcode belongs to the extended set
  function automatic logic is_ext(input logic [7:0] op);
    is_ext = (op >= `MCI_OP_ARITH_FIRST && op <= `MCI_OP_GOTO_POS_ACC) ||
             (op >= `MCI_OP_RESTART && op <= `MCI_OP_SPIN_POS_ACC) ||
             (op >= `MCI_OP_WRITE_IDX && op <= `MCI_OP_ACC_TO_IDX) ||
             (op == `MCI_OP_COND_CALL);
  endfunction

  // True when the opcode is one of the base commands handled here
  function automatic logic is_base(input logic [7:0] op);
    case (op)
      `MCI_OP_SPIN_POS, `MCI_OP_SPIN_NEG, `MCI_OP_SOFT_HALT, `MCI_OP_GOTO_POS,
      `MCI_OP_SET_AXIS, `MCI_OP_GET_AXIS, `MCI_OP_SET_GLOBAL, `MCI_OP_GET_GLOBAL,
      `MCI_OP_CALC, `MCI_OP_COMPARE, `MCI_OP_JUMP_COND, `MCI_OP_JUMP,
      `MCI_OP_CALL_SUB, `MCI_OP_RET_SUB, `MCI_OP_IRQ_ENABLE,
      `MCI_OP_IRQ_DISABLE, `MCI_OP_PROG_STOP, `MCI_OP_CALCX,
      `MCI_OP_ACC_TO_AXIS, `MCI_OP_SET_VECTOR, `MCI_OP_RET_IRQ: is_base = 1'b1;
      default: is_base = 1'b0;
    endcase
  endfunction

  mci_ctx_if ctx ();

  mci_state_t       state_q;
  logic [9:0]       pc_q;
  logic [31:0]      acc_q;
  logic [31:0]      xreg_q;
  logic [3:0]       flags_q;
  logic [NSRC-1:0]  pend_q;
  logic [NSRC-1:0]  src_en_q;
  logic [NSRC-1:0]  vec_ok_q;
  logic [9:0]       vec_q [NSRC];
  logic             gie_q;
  logic [1:0]       sel_q;
  logic             take;
  logic [1:0]       take_idx;
  logic             ext_ok;
  logic             known;
  logic             prog_cmd;
  logic [NSRC-1:0]  set_en;
  logic [NSRC-1:0]  clr_en;
  logic [NSRC-1:0]  set_vec;
  logic [NSRC-1:0]  ack;

  mci_ctx_store u_store (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .ctx     (ctx)
  );

  // Decode and acceptance
  assign ext_ok      = (i_fw_rev >= `MCI_EXT_MIN_REV);
  assign known       = is_base(i_cmd_op) || (is_ext(i_cmd_op) && ext_ok);
  assign o_cmd_ready = (state_q == MCI_RUN) || (state_q == MCI_HANDLE);
  assign o_cmd_known = known;
  assign prog_cmd    = i_cmd_valid && o_cmd_ready && known && !i_cmd_direct;

  // Pick lowest pending enabled source with a vector; gated off inside a handler
  always_comb begin
    take     = 1'b0;
    take_idx = 2'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (pend_q[k] && src_en_q[k] && vec_ok_q[k]) begin
        take     = gie_q && (state_q == MCI_RUN);
        take_idx = 2'(k);
      end
    end
  end

  // Per-source enable, vector and pending logic
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      assign set_en[g]  = prog_cmd && i_cmd_op == `MCI_OP_IRQ_ENABLE &&
                          i_cmd_type == 8'(g);
      assign clr_en[g]  = prog_cmd && i_cmd_op == `MCI_OP_IRQ_DISABLE &&
                          i_cmd_type == 8'(g);
      assign set_vec[g] = prog_cmd && i_cmd_op == `MCI_OP_SET_VECTOR &&
                          i_cmd_type == 8'(g);
      assign ack[g]     = take && take_idx == 2'(g);

      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          pend_q[g]   <= 1'b0;
          src_en_q[g] <= 1'b0;
          vec_ok_q[g] <= 1'b0;
          vec_q[g]    <= `MCI_PC_RESET;
        end else begin
          pend_q[g] <= i_irq_src[g] | (pend_q[g] & ~ack[g]);
          if (set_en[g]) begin
            src_en_q[g] <= 1'b1;
          end else if (clr_en[g]) begin
            src_en_q[g] <= 1'b0;
          end
          if (set_vec[g]) begin
            vec_ok_q[g] <= 1'b1;
            vec_q[g]    <= i_cmd_value[9:0];
          end
        end
      end
    end
  endgenerate

  // Global interrupt enable by number 255
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gie_q <= 1'b0;
    end else if (prog_cmd && i_cmd_type == `MCI_IRQ_GLOBAL) begin
      if (i_cmd_op == `MCI_OP_IRQ_ENABLE) begin
        gie_q <= 1'b1;
      end else if (i_cmd_op == `MCI_OP_IRQ_DISABLE) begin
        gie_q <= 1'b0;
      end
    end
  end

  // Dispatch state machine
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= MCI_RUN;
      sel_q   <= 2'h0;
    end else begin
      case (state_q)
        MCI_RUN: begin
          if (take) begin
            state_q <= MCI_SAVE;
            sel_q   <= take_idx;
          end
        end
        MCI_SAVE:   state_q <= MCI_HANDLE;
        MCI_HANDLE: begin
          if (prog_cmd && i_cmd_op == `MCI_OP_RET_IRQ) begin
            state_q <= MCI_REST;
          end
        end
        MCI_REST:   state_q <= MCI_RUN;
        default:    state_q <= MCI_RUN;
      endcase
    end
  end

  // Context save and restore requests
  assign ctx.save        = (state_q == MCI_SAVE);
  assign ctx.restore     = (state_q == MCI_REST);
  assign ctx.wdata.acc   = acc_q;
  assign ctx.wdata.xreg  = xreg_q;
  assign ctx.wdata.flags = flags_q;
  assign ctx.wdata.pc    = pc_q;

  // Program counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pc_q <= `MCI_PC_RESET;
    end else if (state_q == MCI_SAVE) begin
      pc_q <= vec_q[sel_q];
    end else if (state_q == MCI_REST) begin
      pc_q <= ctx.rdata.pc;
    end else if (prog_cmd) begin
      if (i_cmd_op == `MCI_OP_RESTART) begin
        pc_q <= `MCI_PC_RESET;
      end else if (i_cmd_op == `MCI_OP_JUMP) begin
        pc_q <= i_cmd_value[9:0];
      end else begin
        pc_q <= pc_q + 10'h001;
      end
    end
  end

  // Accumulator, X register and flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc_q   <= '0;
      xreg_q  <= '0;
      flags_q <= '0;
    end else if (state_q == MCI_REST) begin
      acc_q   <= ctx.rdata.acc;
      xreg_q  <= ctx.rdata.xreg;
      flags_q <= ctx.rdata.flags;
    end else if (prog_cmd) begin
      if (i_cmd_op == `MCI_OP_CALCX && i_cmd_type == `MCI_CALCX_LOAD_X) begin
        xreg_q <= acc_q;
      end
      case (i_cmd_op)
        `MCI_OP_GET_AXIS, `MCI_OP_GET_GLOBAL, `MCI_OP_READ_IDX:
          acc_q <= i_read_value;
        default: acc_q <= acc_q;
      endcase
      if (i_flags_we) begin
        flags_q <= i_flags_new;
      end
    end
  end

  // Motion outputs: mode, direction and axis parameter write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_axis_we      <= 1'b0;
      o_axis_param   <= '0;
      o_axis_motor   <= '0;
      o_axis_value   <= '0;
      o_axis_mode    <= MCI_MODE_POS;
      o_dir_positive <= 1'b1;
      o_restart      <= 1'b0;
    end else begin
      o_axis_we <= 1'b0;
      o_restart <= prog_cmd && i_cmd_op == `MCI_OP_RESTART;
      if (i_cmd_valid && o_cmd_ready && known) begin
        o_axis_motor <= i_cmd_motor;
        case (i_cmd_op)
          `MCI_OP_SPIN_POS, `MCI_OP_SPIN_POS_ACC: begin
            o_axis_mode    <= MCI_MODE_VEL;
            o_axis_we      <= 1'b1;
            o_axis_param   <= `MCI_AP_TARGET_VEL;
            o_axis_value   <= (i_cmd_op == `MCI_OP_SPIN_POS) ? i_cmd_value : acc_q;
            o_dir_positive <= 1'b1;
          end
          `MCI_OP_SPIN_NEG, `MCI_OP_SPIN_NEG_ACC: begin
            o_axis_mode    <= MCI_MODE_VEL;
            o_axis_we      <= 1'b1;
            o_axis_param   <= `MCI_AP_TARGET_VEL;
            o_axis_value   <= (i_cmd_op == `MCI_OP_SPIN_NEG) ? i_cmd_value : acc_q;
            o_dir_positive <= 1'b0;
          end
          `MCI_OP_SOFT_HALT: begin
            o_axis_mode  <= MCI_MODE_VEL;
            o_axis_we    <= 1'b1;
            o_axis_param <= `MCI_AP_TARGET_VEL;
            o_axis_value <= '0;
          end
          `MCI_OP_GOTO_POS_ACC: begin
            o_axis_mode  <= MCI_MODE_POS;
            o_axis_we    <= 1'b1;
            o_axis_param <= `MCI_AP_TARGET_POS;
            o_axis_value <= acc_q;
          end
          default: o_axis_we <= 1'b0;
        endcase
      end
    end
  end

  assign o_pc         = pc_q;
  assign o_acc        = acc_q;
  assign o_xreg       = xreg_q;
  assign o_flags      = flags_q;
  assign o_in_handler = (state_q != MCI_RUN);
endmodule

/* File: sim/mci_engine_chk.sv */
// Port-level checks on the command engine
module mci_engine_chk (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_fw_rev,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_direct,
  input  wire logic [7:0]  i_cmd_op,
  input  wire logic [31:0] i_cmd_value,
  input  wire logic        o_cmd_ready,
  input  wire logic        o_cmd_known,
  input  wire logic        o_in_handler,
  input  wire logic [31:0] o_acc,
  input  wire logic        o_axis_we,
  input  wire logic [7:0]  o_axis_param,
  input  wire logic [31:0] o_axis_value,
  input  wire logic [1:0]  o_axis_mode,
  input  wire logic        o_dir_positive,
  input  wire logic        o_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic ext;
  logic prog_rst;
  // Accepted command, program restart and extended opcode group
  assign take     = i_cmd_valid & o_cmd_ready & o_cmd_known;
  assign prog_rst = take & !i_cmd_direct & (i_cmd_op == 8'h30);
  assign ext  = i_cmd_op inside {[8'h28:8'h2e], [8'h30:8'h33], [8'h37:8'h39], 8'h50};

  a_spin_pos_out:
    assert property (take && i_cmd_op == 8'h01 |=> o_axis_we && o_axis_param == 8'h02
      && o_axis_value == $past(i_cmd_value) && o_axis_mode == 2'h1 && o_dir_positive)
    else $error("spin positive output wrong");
  a_spin_neg_out:
    assert property (take && i_cmd_op == 8'h02 |=> o_axis_we && o_axis_param == 8'h02
      && o_axis_value == $past(i_cmd_value) && o_axis_mode == 2'h1 && !o_dir_positive)
    else $error("spin negative output wrong");
  a_halt_zero_vel:
    assert property (take && i_cmd_op == 8'h03 |=> o_axis_we && o_axis_param == 8'h02
      && o_axis_value == 32'h0 && o_axis_mode == 2'h1)
    else $error("soft halt output wrong");
  a_ext_refused:
    assert property (ext && i_fw_rev < 16'h012e |-> !o_cmd_known)
    else $error("extended opcode accepted on old revision");
  a_ext_known:
    assert property (ext && i_fw_rev >= 16'h012e |-> o_cmd_known)
    else $error("extended opcode not decoded");
  a_restart_pulse:
    assert property (o_restart == $past(prog_rst))
    else $error("restart pulse wrong");
  a_direct_acc_kept:
    assert property (take && i_cmd_direct |=> $stable(o_acc))
    else $error("direct command changed accumulator");
  a_save_one_cycle:
    assert property ($rose(o_in_handler) |-> !o_cmd_ready ##1 o_cmd_ready)
    else $error("context save not one cycle");
  a_no_nesting:
    assert property (o_in_handler && o_cmd_ready && !(take && i_cmd_op == 8'h26)
      |=> o_in_handler && o_cmd_ready)
    else $error("handler left or nested");
  a_rest_exit:
    assert property (o_in_handler && $past(o_in_handler) && !o_cmd_ready |=> !o_in_handler)
    else $error("restore did not resume program");
  // Main scenarios reached
  c_halt: cover property (take && i_cmd_op == 8'h03);
  c_enter: cover property ($rose(o_in_handler));
  c_direct_read: cover property (take && i_cmd_direct && i_cmd_op == 8'h06);
endmodule

bind mci_engine mci_engine_chk u_chk (.i_clk, .i_rst_n, .i_fw_rev, .i_cmd_valid,
  .i_cmd_direct, .i_cmd_op, .i_cmd_value, .o_cmd_ready, .o_cmd_known, .o_in_handler,
  .o_acc, .o_axis_we, .o_axis_param, .o_axis_value, .o_axis_mode, .o_dir_positive,
  .o_restart);

/* File: sim/mci_motion_model.sv */
// Motion controller stand-in: keeps target velocity, returns it on reads
module mci_motion_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_param,
  input  wire logic [31:0] i_value,
  output logic [31:0]      o_tgt_vel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Target velocity parameter store
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_tgt_vel <= 32'h0;
    else if (i_we && i_param == 8'h02) o_tgt_vel <= i_value;
  end
endmodule

/* File: sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, valid = 0, direct = 0, ready, known, in_h;
  logic        we, dir_pos, restart, flags_we = 0;
  logic [15:0] rev = 16'h012e;
  logic [7:0]  op = 8'h00, typ = 8'h00, motor = 8'h00, param, amotor;
  logic [2:0]  irq = 3'h0;
  logic [3:0]  flags_new = 4'h0, flags;
  logic [31:0] value = 32'h0, acc, vel, avalue, xreg;
  logic [9:0]  pc, exp_pc = 10'h000;
  logic [1:0]  mode;
  int          err_count = 0, total_checks = 0, cycles = 0, restart_seen = 0;
  logic [7:0]  ext_ops [15] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30,
                                8'h31, 8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h50};

  mci_engine uut (.i_clk(clk), .i_rst_n(rst_n), .i_fw_rev(rev), .i_cmd_valid(valid),
    .i_cmd_direct(direct), .i_cmd_op(op), .i_cmd_type(typ), .i_cmd_motor(motor),
    .i_cmd_value(value), .i_read_value(vel), .i_flags_new(flags_new), .i_flags_we(flags_we),
    .i_irq_src(irq), .o_cmd_ready(ready), .o_cmd_known(known), .o_pc(pc),
    .o_in_handler(in_h), .o_acc(acc), .o_xreg(xreg), .o_flags(flags), .o_axis_we(we),
    .o_axis_param(param), .o_axis_motor(amotor), .o_axis_value(avalue), .o_axis_mode(mode),
    .o_dir_positive(dir_pos), .o_restart(restart));
  mci_motion_model u_motion (.i_clk(clk), .i_rst_n(rst_n), .i_we(we), .i_param(param),
    .i_value(avalue), .o_tgt_vel(vel));

  initial begin
    forever #4 clk = ~clk;
  end
  // Restart pulses seen at the port, sampled where settled
  always @(negedge clk) begin
    if (restart === 1'b1) restart_seen++;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  // One command, held until taken, then released and settled
  task automatic issue(input logic [7:0] o, input logic [7:0] t, input logic [7:0] m,
                       input logic [31:0] v, input logic d);
    int n;
    @(negedge clk);
    op = o; typ = t; motor = m; value = v; direct = d; valid = 1'b1;
    #1;
    for (n = 0; n < 20 && !(ready && known); n++) begin
      @(negedge clk);
      #1;
    end
    if (n == 20) chk(32'h1, 32'h0, "command not taken");
    @(negedge clk);
    valid = 1'b0;
    if (!d) exp_pc = exp_pc + 10'h1;
    @(negedge clk);
  endtask

  task automatic t_decode();
    foreach (ext_ops[i]) begin
      @(negedge clk);
      op = ext_ops[i];
      rev = 16'h012d;
      #1 chk(known, 1'b0, "extended opcode accepted early");
      @(negedge clk);
      rev = 16'h012e;
      #1 chk(known, 1'b1, "extended opcode refused");
    end
    @(negedge clk);
    rev = 16'h012d;
    for (int k = 1; k < 4; k++) begin
      @(negedge clk);
      op = 8'(k);
      #1 chk(known, 1'b1, "motion opcode refused");
    end
    @(negedge clk);
    rev = 16'h012e;
    $display("test decode done");
  endtask

  task automatic t_motion();
    issue(8'h01, 8'h00, 8'h00, 32'h3e8, 1'b1);
    chk(mode, 2'h1, "spin mode");
    chk(param, 8'h02, "spin parameter");
    chk(dir_pos, 1'b1, "spin positive direction");
    chk(vel, 32'h3e8, "spin positive velocity");
    issue(8'h06, 8'h02, 8'h00, 32'h0, 1'b0);
    chk(acc, 32'h3e8, "motion read to accumulator");
    issue(8'h02, 8'h00, 8'h01, 32'h1f4, 1'b1);
    chk(dir_pos, 1'b0, "spin negative direction");
    chk(vel, 32'h1f4, "spin negative velocity");
    chk(amotor, 8'h01, "motor field");
    issue(8'h33, 8'h00, 8'h00, 32'h0, 1'b1);
    chk(dir_pos, 1'b1, "spin positive acc direction");
    chk(vel, 32'h3e8, "spin positive acc velocity");
    issue(8'h32, 8'h00, 8'h00, 32'h0, 1'b1);
    chk(dir_pos, 1'b0, "spin negative acc direction");
    issue(8'h2e, 8'h00, 8'h00, 32'h0, 1'b1);
    chk(mode, 2'h0, "goto position mode");
    chk(param, 8'h00, "goto position parameter");
    chk(avalue, 32'h3e8, "goto position value");
    issue(8'h03, 8'h00, 8'h00, 32'h55, 1'b1);
    chk(mode, 2'h1, "halt mode");
    chk(vel, 32'h0, "halt velocity");
    $display("test motion done");
  endtask

  task automatic t_irq();
    logic [9:0] saved;
    int n;
    issue(8'h09, 8'h00, 8'h03, 32'h3e8, 1'b0);
    issue(8'h25, 8'h00, 8'h00, 32'h40, 1'b0);
    issue(8'h19, 8'h00, 8'h00, 32'h0, 1'b0);
    issue(8'h01, 8'h00, 8'h00, 32'h3e8, 1'b1);
    flags_new = 4'h5;
    flags_we = 1'b1;
    issue(8'h06, 8'h02, 8'h00, 32'h0, 1'b0);
    flags_we = 1'b0;
    chk(acc, 32'h3e8, "program read to accumulator");
    chk(flags, 4'h5, "flag update");
    issue(8'h21, 8'h00, 8'h00, 32'h0, 1'b0);
    chk(xreg, 32'h3e8, "accumulator to X register");
    issue(8'h01, 8'h00, 8'h00, 32'h7, 1'b1);
    issue(8'h06, 8'h02, 8'h00, 32'h0, 1'b1);
    chk(acc, 32'h3e8, "direct read changed accumulator");
    irq[0] = 1'b1;
    @(negedge clk);
    irq[0] = 1'b0;
    repeat (5) @(negedge clk);
    chk(in_h, 1'b0, "handler entered while disabled");
    issue(8'h19, 8'hff, 8'h00, 32'h0, 1'b0);
    saved = exp_pc;
    for (n = 0; n < 10 && !(in_h && ready); n++) @(negedge clk);
    chk(in_h, 1'b1, "handler not entered");
    chk(pc, 10'h040, "handler vector");
    flags_new = 4'ha;
    flags_we = 1'b1;
    issue(8'h06, 8'h02, 8'h00, 32'h0, 1'b0);
    flags_we = 1'b0;
    chk(acc, 32'h7, "handler read");
    chk(flags, 4'ha, "handler flags");
    issue(8'h21, 8'h00, 8'h00, 32'h0, 1'b0);
    chk(xreg, 32'h7, "handler X register");
    issue(8'h26, 8'h00, 8'h00, 32'h0, 1'b0);
    @(negedge clk);
    chk(in_h, 1'b0, "handler not left");
    chk(acc, 32'h3e8, "accumulator restore");
    chk(xreg, 32'h3e8, "X register restore");
    chk(flags, 4'h5, "flags restore");
    chk(pc, saved, "resume address");
    $display("test irq done");
  endtask

  task automatic t_restart();
    issue(8'h30, 8'h00, 8'h00, 32'h0, 1'b0);
    chk(pc, 10'h000, "restart address");
    chk(restart_seen, 32'h1, "restart pulse");
    $display("test restart done");
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_decode();
    t_motion();
    t_irq();
    t_restart();
    stop_test();
  end
endmodule
